// *** design/nrh_read_host.sv ***
// Purpose: Host controller issuing page and cached reads to a NAND flash
// Assumes: Flash pins wired directly; ready_busy_n pulled up outside
// Notes: Program and erase are never issued; write protect held low
// Overview of operation
// - Address cycles one, two carry column
// - Cycles three, four carry row address
// - Input latched on write strobe rise
// - Reading toggles output strobe, latches low
// - Write protect high only during program
// - Strobes high while busy; status, reset only
// - Page read: 00h, address, 30h
// - Block change restarts with normal read
`timescale 1ns/100ps
`default_nettype none
`include "nrh_params.svh"
module nrh_read_host
    import nrh_pkg::*;
#(
    parameter int FETCH_CYC = `NRH_FETCH_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire nrh_op_t i_op,
    input wire logic [11:0] i_column_addr,
    input wire logic [15:0] i_row_addr,
    input wire logic [11:0] i_byte_count,
    output logic o_busy,
    output logic o_done,
    output logic o_timeout,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    output logic o_chip_select_n,
    output logic o_cmd_latch_en,
    output logic o_addr_latch_en,
    output logic o_write_strobe_n,
    output logic o_output_strobe_n,
    output logic o_write_protect_n,
    output logic [7:0] o_data_port,
    output logic o_data_port_oe,
    input wire logic [7:0] i_data_port,
    input wire logic i_ready_busy_n
);
    typedef enum logic [2:0] {
        S_IDLE, S_ISSUE, S_WAIT, S_WB, S_BUSY, S_READ
    } nrh_state_t;

    nrh_bus_if bus();
    nrh_state_t st_r;
    logic [7:0] seq_r [0:7];
    logic [2:0] len_r;
    logic [2:0] idx_r;
    logic wait_rb_r;
    logic [11:0] left_r;
    logic [31:0] tmo_r;
    logic [31:0] wb_r;
    logic [2:0] rb_sync_r;
    logic rb_q_r;
    logic [7:0] d1_r;
    logic [7:0] d2_r;
    logic [2:0] kind_mask_r;
    logic [7:0] cmd_mask_r;
    logic req_r;
    nrh_cycle_t kind_r;
    logic [7:0] wdata_r;

    assign bus.req = req_r;
    assign bus.kind = kind_r;
    assign bus.wdata = wdata_r;

    // Column low, column high nibble with upper bits low
    function automatic logic [7:0] col_hi(input logic [11:0] c);
        col_hi = {4'h0, c[11:8]};
    endfunction

    // ********************
    // Pin synchronisers
    // ********************
    // Ready/busy counts once second and third stage agree
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rb_sync_r <= 3'h0;
            rb_q_r <= 1'b0;
        end else begin
            rb_sync_r <= {rb_sync_r[1:0], i_ready_busy_n};
            if (rb_sync_r[1] == rb_sync_r[2]) begin
                rb_q_r <= rb_sync_r[2];
            end
        end
    end
    // Data port: only second stage feeds the engine
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            d1_r <= 8'h00;
            d2_r <= 8'h00;
        end else begin
            d1_r <= i_data_port;
            d2_r <= d1_r;
        end
    end

    nrh_cycle_eng u_eng (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .bus(bus),
        .i_data_sync(d2_r),
        .o_cmd_latch_en(o_cmd_latch_en),
        .o_addr_latch_en(o_addr_latch_en),
        .o_write_strobe_n(o_write_strobe_n),
        .o_output_strobe_n(o_output_strobe_n),
        .o_data(o_data_port),
        .o_data_oe(o_data_port_oe)
    );

    // ********************
    // Operation sequencer
    // ********************
    // Builds the cycle list per operation, then walks it
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= S_IDLE;
            len_r <= 3'h0;
            idx_r <= 3'h0;
            wait_rb_r <= 1'b0;
            left_r <= 12'h000;
            tmo_r <= 32'h0;
            wb_r <= 32'h0;
            kind_mask_r <= 3'h0;
            cmd_mask_r <= 8'h00;
            req_r <= 1'b0;
            kind_r <= NRH_CY_CMD;
            wdata_r <= 8'h00;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_timeout <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
            o_chip_select_n <= 1'b1;
            o_write_protect_n <= 1'b0;
            for (int k = 0; k < 8; k++) begin
                seq_r[k] <= 8'h00;
            end
        end else begin
            o_done <= 1'b0;
            o_rd_valid <= 1'b0;
            req_r <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    // Deselect when idle and ready for standby
                    o_chip_select_n <= rb_q_r;
                    left_r <= i_byte_count;
                    idx_r <= 3'h0;
                    // New commands wait for ready, except reset
                    if (i_start && i_op != NRH_OP_IDLE && (rb_q_r || i_op == NRH_OP_RESET)) begin
                        o_busy <= 1'b1;
                        o_timeout <= 1'b0;
                        o_chip_select_n <= 1'b0;
                        st_r <= S_ISSUE;
                        wait_rb_r <= 1'b1;
                        kind_mask_r <= 3'h0;
                        case (i_op)
                            NRH_OP_PAGE_READ: begin
                                // Setup, four address cycles, start
                                seq_r[0] <= `NRH_CMD_READ_SETUP;
                                seq_r[1] <= i_column_addr[7:0];
                                seq_r[2] <= col_hi(i_column_addr);
                                seq_r[3] <= i_row_addr[7:0];
                                seq_r[4] <= i_row_addr[15:8];
                                seq_r[5] <= `NRH_CMD_READ_START;
                                cmd_mask_r <= 8'h21;
                                len_r <= 3'd6;
                            end
                            NRH_OP_CACHE_NEXT: begin
                                seq_r[0] <= `NRH_CMD_CACHE_READ;
                                cmd_mask_r <= 8'h01;
                                len_r <= 3'd1;
                            end
                            NRH_OP_CACHE_LAST: begin
                                seq_r[0] <= `NRH_CMD_CACHE_LAST;
                                cmd_mask_r <= 8'h01;
                                len_r <= 3'd1;
                            end
                            NRH_OP_COL_CHANGE: begin
                                // Output column change: no busy period
                                seq_r[0] <= `NRH_CMD_COL_CHG;
                                seq_r[1] <= i_column_addr[7:0];
                                seq_r[2] <= col_hi(i_column_addr);
                                seq_r[3] <= `NRH_CMD_COL_CHG_GO;
                                cmd_mask_r <= 8'h09;
                                len_r <= 3'd4;
                                wait_rb_r <= 1'b0;
                            end
                            NRH_OP_RESET: begin
                                seq_r[0] <= `NRH_CMD_RESET;
                                cmd_mask_r <= 8'h01;
                                len_r <= 3'd1;
                            end
                            default: begin
                                // Byte read from current cache column
                                len_r <= 3'd0;
                                wait_rb_r <= 1'b0;
                                st_r <= S_READ;
                            end
                        endcase
                    end
                end
                S_ISSUE: begin
                    if (idx_r == len_r) begin
                        wb_r <= 32'(`NRH_WB_CYC);
                        st_r <= wait_rb_r ? S_WB : S_IDLE;
                        o_done <= !wait_rb_r;
                        o_busy <= wait_rb_r;
                    end else begin
                        req_r <= 1'b1;
                        kind_r <= cmd_mask_r[idx_r] ? NRH_CY_CMD : NRH_CY_ADDR;
                        wdata_r <= seq_r[idx_r];
                        st_r <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (bus.done) begin
                        idx_r <= idx_r + 3'h1;
                        st_r <= S_ISSUE;
                    end
                end
                S_WB: begin
                    // Busy appears within 100 ns of the last write edge
                    if (wb_r > 32'h1) begin
                        wb_r <= wb_r - 32'h1;
                    end else begin
                        tmo_r <= 32'(FETCH_CYC) + 32'(`NRH_WB_CYC) + 32'h4;
                        st_r <= S_BUSY;
                    end
                end
                S_BUSY: begin
                    // Strobes stay high; chip select held low
                    if (rb_q_r) begin
                        o_done <= 1'b1;
                        o_busy <= 1'b0;
                        st_r <= S_IDLE;
                    end else if (tmo_r == 32'h0) begin
                        o_timeout <= 1'b1;
                        o_done <= 1'b1;
                        o_busy <= 1'b0;
                        st_r <= S_IDLE;
                    end else begin
                        tmo_r <= tmo_r - 32'h1;
                    end
                end
                S_READ: begin
                    // One byte per strobe; column advances in the flash
                    if (left_r == 12'h000) begin
                        o_done <= 1'b1;
                        o_busy <= 1'b0;
                        st_r <= S_IDLE;
                    end else if (bus.done) begin
                        o_rd_valid <= 1'b1;
                        o_rd_data <= bus.rdata;
                        left_r <= left_r - 12'h001;
                    end else if (!req_r && !o_output_strobe_n == 1'b0 && kind_r != NRH_CY_READ) begin
                        req_r <= 1'b1;
                        kind_r <= NRH_CY_READ;
                    end else if (!req_r && kind_r == NRH_CY_READ && !bus.done) begin
                        kind_r <= NRH_CY_CMD;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // Write protect never rises: reads only
    property p_wp_low;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !o_write_protect_n;
    endproperty
    a_wp_low: assert property (p_wp_low) else $error("write protect raised");
    // Strobes high while waiting on busy
    property p_busy_quiet;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (st_r == S_BUSY) |-> o_write_strobe_n && o_output_strobe_n && !o_chip_select_n;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("strobe during busy");
    // Wait on busy ends within the bound
    sequence s_enter_busy;
        $rose(st_r == S_BUSY);
    endsequence
    property p_busy_bound;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        s_enter_busy |-> (tmo_r <= 32'(FETCH_CYC) + 32'(`NRH_WB_CYC) + 32'h4);
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("busy bound wrong");
    property p_select_in_op;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (st_r == S_WAIT) |-> !o_chip_select_n;
    endproperty
    a_select_in_op: assert property (p_select_in_op) else $error("cycle while deselected");
endmodule
`default_nettype wire

// *** design/nrh_params.svh ***
// Purpose: Constants for the NAND read host controller
// Assumes: 125 MHz system clock, 8 ns period
// Notes: Times in ns except the fetch time in us, counts derived from the clock period
`ifndef NRH_PARAMS_SVH
`define NRH_PARAMS_SVH
`define NRH_CLK_NS 8
// Command codes
`define NRH_CMD_READ_SETUP 8'h00
`define NRH_CMD_READ_START 8'h30
`define NRH_CMD_COL_CHG 8'h05
`define NRH_CMD_COL_CHG_GO 8'he0
`define NRH_CMD_CACHE_READ 8'h31
`define NRH_CMD_CACHE_LAST 8'h3f
`define NRH_CMD_STATUS 8'h70
`define NRH_CMD_RESET 8'hff
// Address layout
`define NRH_PAGE_BYTES 2176
`define NRH_MAIN_BYTES 2048
`define NRH_SPARE_BYTES 128
`define NRH_COL_W 12
`define NRH_ROW_W 16
`define NRH_PAGE_BITS 6
// Strobe phase: 25 ns least cycle, 12 ns least low pulse
`define NRH_PHASE_NS 16
`define NRH_PHASE_CYC ((`NRH_PHASE_NS + `NRH_CLK_NS - 1) / `NRH_CLK_NS)
// Output access time, sampled after the falling strobe
`define NRH_ACCESS_NS 20
`define NRH_ACCESS_CYC ((`NRH_ACCESS_NS + `NRH_CLK_NS - 1) / `NRH_CLK_NS)
// Write high to busy, 100 ns
`define NRH_WB_NS 100
`define NRH_WB_CYC ((`NRH_WB_NS + `NRH_CLK_NS - 1) / `NRH_CLK_NS)
// Array fetch and cache busy, 25 us longest
`define NRH_FETCH_US 25
`define NRH_FETCH_CYC ((`NRH_FETCH_US * 1000) / `NRH_CLK_NS)
`endif

// *** design/nrh_pkg.sv ***
// Purpose: Types for the NAND read host controller
// Assumes: Nothing beyond the params header
// Notes: Operation codes on the user port
package nrh_pkg;
    typedef enum logic [2:0] {
        NRH_OP_PAGE_READ,
        NRH_OP_CACHE_NEXT,
        NRH_OP_CACHE_LAST,
        NRH_OP_COL_CHANGE,
        NRH_OP_READ_BYTES,
        NRH_OP_RESET,
        NRH_OP_IDLE
    } nrh_op_t;
    typedef enum logic [1:0] {
        NRH_CY_CMD,
        NRH_CY_ADDR,
        NRH_CY_READ
    } nrh_cycle_t;
endpackage

// *** design/nrh_bus_if.sv ***
// Purpose: Link between sequencer and pin cycle engine
// Assumes: Single clock domain
// Notes: One request at a time, done pulses once
`timescale 1ns/100ps
`default_nettype none
interface nrh_bus_if;
    import nrh_pkg::*;
    logic req;
    nrh_cycle_t kind;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport seq (output req, output kind, output wdata, input done, input rdata);
    modport eng (input req, input kind, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// *** design/nrh_cycle_eng.sv ***
// Purpose: Drives one command, address or read cycle on the pins
// Assumes: Pins reach the flash directly; data input already synchronised
// Notes: Latch enables and strobes come from flops
`timescale 1ns/100ps
`default_nettype none
`include "nrh_params.svh"
module nrh_cycle_eng
    import nrh_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    nrh_bus_if.eng bus,
    input wire logic [7:0] i_data_sync,
    output logic o_cmd_latch_en,
    output logic o_addr_latch_en,
    output logic o_write_strobe_n,
    output logic o_output_strobe_n,
    output logic [7:0] o_data,
    output logic o_data_oe
);
    localparam logic [3:0] PHASE = 4'(`NRH_PHASE_CYC);
    localparam logic [3:0] ACC = 4'(`NRH_ACCESS_CYC + 3);
    typedef enum logic [1:0] {E_IDLE, E_LOW, E_HIGH} nrh_eng_t;
    nrh_eng_t st_r;
    logic [3:0] cnt_r;
    logic rd_r;

    // ********************
    // Strobe sequencing
    // ********************
    // Low phase then high phase; read waits out access plus sync delay
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= E_IDLE;
            cnt_r <= 4'h0;
            rd_r <= 1'b0;
            o_cmd_latch_en <= 1'b0;
            o_addr_latch_en <= 1'b0;
            o_write_strobe_n <= 1'b1;
            o_output_strobe_n <= 1'b1;
            o_data <= 8'h00;
            o_data_oe <= 1'b0;
            bus.done <= 1'b0;
            bus.rdata <= 8'h00;
        end else begin
            bus.done <= 1'b0;
            case (st_r)
                E_IDLE: begin
                    if (bus.req) begin
                        rd_r <= (bus.kind == NRH_CY_READ);
                        // Latch enables pick command or address; both low reads
                        o_cmd_latch_en <= (bus.kind == NRH_CY_CMD);
                        o_addr_latch_en <= (bus.kind == NRH_CY_ADDR);
                        if (bus.kind == NRH_CY_READ) begin
                            o_output_strobe_n <= 1'b0;
                            o_data_oe <= 1'b0;
                            cnt_r <= ACC;
                        end else begin
                            o_write_strobe_n <= 1'b0;
                            o_data <= bus.wdata;
                            o_data_oe <= 1'b1;
                            cnt_r <= PHASE;
                        end
                        st_r <= E_LOW;
                    end
                end
                E_LOW: begin
                    if (cnt_r > 4'h1) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else begin
                        // Rising edge latches input cycle in the flash
                        o_write_strobe_n <= 1'b1;
                        o_output_strobe_n <= 1'b1;
                        if (rd_r) begin
                            bus.rdata <= i_data_sync;
                        end
                        cnt_r <= PHASE;
                        st_r <= E_HIGH;
                    end
                end
                E_HIGH: begin
                    if (cnt_r > 4'h1) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else begin
                        o_data_oe <= 1'b0;
                        o_cmd_latch_en <= 1'b0;
                        o_addr_latch_en <= 1'b0;
                        bus.done <= 1'b1;
                        st_r <= E_IDLE;
                    end
                end
                default: st_r <= E_IDLE;
            endcase
        end
    end

    // Hold time after write rising edge must keep data valid
    property p_hold_data;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        $rose(o_write_strobe_n) |-> o_data_oe && $stable(o_data);
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("data moved at strobe");
    property p_no_drive_read;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !o_output_strobe_n |-> !o_data_oe && o_write_strobe_n;
    endproperty
    a_no_drive_read: assert property (p_no_drive_read) else $error("drove during read");
    property p_read_latches_low;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !o_output_strobe_n |-> !o_cmd_latch_en && !o_addr_latch_en;
    endproperty
    a_read_latches_low: assert property (p_read_latches_low) else $error("latch high in read");
    property p_one_latch;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !(o_cmd_latch_en && o_addr_latch_en);
    endproperty
    a_one_latch: assert property (p_one_latch) else $error("both latches high");
endmodule
`default_nettype wire

// *** tb/nrh_flash_model.sv ***
// Purpose: Pin-level NAND flash model facing the read host
// Assumes: The clock only times busy periods
// Notes: A byte reads as column low byte xor page low byte
`timescale 1ns/100ps
`default_nettype none
module nrh_flash_model #(
    parameter int BUSY_CYC = 40
) (
    input wire logic i_clk,
    input wire logic i_slow,
    input wire logic i_cs_n,
    input wire logic i_cmd_en,
    input wire logic i_addr_en,
    input wire logic i_wstb_n,
    input wire logic i_ostb_n,
    input wire logic [7:0] i_host,
    input wire logic i_oe,
    output logic [7:0] o_data,
    output logic o_rb_n
);
    logic [7:0] cmd_q[$];
    logic [7:0] addr_q[$];
    logic [11:0] col_r = 12'h000;
    logic [11:0] col_nxt = 12'h000;
    logic [15:0] row_nxt = 16'h0000;
    logic [15:0] page_r = 16'h0000;
    logic [7:0] dout_r = 8'h00;
    int acnt = 0;
    int cnt = 0;
    int viol = 0;
    logic standby;
    // Pull-up gives ready once the drain lets go
    assign o_rb_n = (cnt == 0);
    assign standby = i_cs_n && o_rb_n;
    // Undriven port shows the last byte inverted, never a stale copy
    assign o_data = (!i_cs_n && !i_ostb_n) ? dout_r : (i_oe ? i_host : ~dout_r);
    // Busy countdown
    always @(posedge i_clk) if (cnt > 0) cnt = cnt - 1;
    task automatic busy_for(input logic [15:0] p, input logic [11:0] c, input int n);
        page_r = p;
        col_r = c;
        cnt = n;
    endtask
    // Input cycles count only while selected with the output strobe idle
    always @(posedge i_wstb_n) begin
        if (!i_cs_n && i_ostb_n && i_cmd_en && !i_addr_en) begin
            cmd_q.push_back(i_host);
            acnt = 0;
            if (cnt == 0 || i_host == 8'h70 || i_host == 8'hff) begin
                case (i_host)
                    8'h30: busy_for(row_nxt, col_nxt, i_slow ? 300 : BUSY_CYC);
                    8'h31, 8'h3f: busy_for(page_r + 16'h1, 12'h000, BUSY_CYC / 2);
                    8'he0: col_r = col_nxt;
                    8'hff: busy_for(page_r, 12'h000, 10);
                    default: ; // Writes stay locked out
                endcase
            end
        end else if (!i_cs_n && i_ostb_n && i_addr_en && !i_cmd_en) begin
            addr_q.push_back(i_host);
            case (acnt)
                0: col_nxt[7:0] = i_host;
                1: col_nxt[11:8] = i_host[3:0];
                2: row_nxt[7:0] = i_host;
                default: row_nxt[15:8] = i_host;
            endcase
            acnt++;
        end
    end
    // Each fall of the output strobe while ready and selected moves one byte out
    always @(negedge i_ostb_n) begin
        if (!o_rb_n && !i_cs_n) begin
            viol++;
        end else if (!i_cs_n && i_wstb_n && !i_cmd_en && !i_addr_en) begin
            dout_r = col_r[7:0] ^ page_r[7:0];
            col_r = col_r + 12'h001;
        end
    end
endmodule
`default_nettype wire

// *** tb/nrh_read_host_tb.sv ***
// Purpose: Self-checking bench for the NAND read host
// Assumes: Flash model on the pins, short fetch count
// Notes: Expected bytes follow the column xor page pattern
`timescale 1ns/100ps
`default_nettype none
module nrh_read_host_tb
    import nrh_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic slow = 1'b0;
    nrh_op_t op = NRH_OP_IDLE;
    logic [11:0] col = 12'h000;
    logic [15:0] row = 16'h0000;
    logic [11:0] nbytes = 12'h000;
    logic busy, done, tmo, rd_valid, cs_n, cmd_en, addr_en, wstb_n, ostb_n, wp_n, oe, rb_n;
    logic [7:0] rd_data, host_d, pin_d;
    logic [7:0] rd_q[$];
    int failures = 0;
    int checks_done = 0;
    always #4 clk = ~clk;
    // Collect bytes as the host hands them up
    always @(posedge clk) if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    nrh_read_host #(.FETCH_CYC(50)) nrh_read_host_inst (.i_clk_sys(clk), .i_rst_b(rst_b),
        .i_start(start), .i_op(op), .i_column_addr(col), .i_row_addr(row),
        .i_byte_count(nbytes), .o_busy(busy), .o_done(done), .o_timeout(tmo),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_chip_select_n(cs_n),
        .o_cmd_latch_en(cmd_en), .o_addr_latch_en(addr_en), .o_write_strobe_n(wstb_n),
        .o_output_strobe_n(ostb_n), .o_write_protect_n(wp_n), .o_data_port(host_d),
        .o_data_port_oe(oe), .i_data_port(pin_d), .i_ready_busy_n(rb_n));
    nrh_flash_model nrh_flash_model_inst (.i_clk(clk), .i_slow(slow), .i_cs_n(cs_n),
        .i_cmd_en(cmd_en), .i_addr_en(addr_en), .i_wstb_n(wstb_n), .i_ostb_n(ostb_n),
        .i_host(host_d), .i_oe(oe), .o_data(pin_d), .o_rb_n(rb_n));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_q(input logic [7:0] q[$], input logic [7:0] e[$]);
        chk(8'(q.size()), 8'(e.size()));
        foreach (e[i]) if (i < q.size()) chk(q[i], e[i]);
    endtask
    // One operation, bounded waits so a hang cannot stall the run
    task automatic run_op(input nrh_op_t o, input logic [11:0] c, input logic [15:0] r,
        input logic [11:0] n);
        int k;
        @(negedge clk);
        op = o;
        col = c;
        row = r;
        nbytes = n;
        start = 1'b1;
        for (k = 0; k < 20 && busy !== 1'b1; k++) @(negedge clk);
        start = 1'b0;
        for (k = 0; k < 2000 && done !== 1'b1; k++) @(negedge clk);
        chk({7'h00, done}, 8'h01);
    endtask
    task automatic clr();
        nrh_flash_model_inst.cmd_q.delete();
        nrh_flash_model_inst.addr_q.delete();
        rd_q.delete();
    endtask
    // Page read at the last column pair of a page
    task automatic t_page();
        clr();
        chk({7'h00, cs_n}, 8'h01);
        run_op(NRH_OP_PAGE_READ, 12'h87e, 16'h0a7d, 12'h000);
        chk_q(nrh_flash_model_inst.cmd_q, '{8'h00, 8'h30});
        chk_q(nrh_flash_model_inst.addr_q, '{8'h7e, 8'h08, 8'h7d, 8'h0a});
        run_op(NRH_OP_READ_BYTES, 12'h000, 16'h0000, 12'h002);
        chk_q(rd_q, '{8'h03, 8'h02});
        $display("test page read done");
    endtask
    // Cached reads stop at the block's last page
    task automatic t_cache();
        clr();
        run_op(NRH_OP_CACHE_NEXT, 12'h000, 16'h0a7d, 12'h000);
        run_op(NRH_OP_READ_BYTES, 12'h000, 16'h0000, 12'h002);
        run_op(NRH_OP_CACHE_LAST, 12'h000, 16'h0a7d, 12'h000);
        run_op(NRH_OP_READ_BYTES, 12'h000, 16'h0000, 12'h002);
        chk_q(nrh_flash_model_inst.cmd_q, '{8'h31, 8'h3f});
        chk_q(rd_q, '{8'h7e, 8'h7f, 8'h7f, 8'h7e});
        $display("test cache read done");
    endtask
    task automatic t_col();
        clr();
        run_op(NRH_OP_COL_CHANGE, 12'h123, 16'h0000, 12'h000);
        run_op(NRH_OP_READ_BYTES, 12'h000, 16'h0000, 12'h002);
        chk_q(nrh_flash_model_inst.cmd_q, '{8'h05, 8'he0});
        chk_q(nrh_flash_model_inst.addr_q, '{8'h23, 8'h01});
        chk_q(rd_q, '{8'h5c, 8'h5b});
        $display("test column change done");
    endtask
    // Busy outlasting the bound: timeout, refusal, reset while busy
    task automatic t_slow();
        clr();
        slow = 1'b1;
        run_op(NRH_OP_PAGE_READ, 12'h000, 16'h0040, 12'h000);
        chk({7'h00, tmo}, 8'h01);
        chk({7'h00, rb_n}, 8'h00);
        op = NRH_OP_PAGE_READ;
        start = 1'b1;
        repeat (8) @(negedge clk);
        chk({7'h00, busy}, 8'h00);
        start = 1'b0;
        run_op(NRH_OP_RESET, 12'h000, 16'h0000, 12'h000);
        chk(nrh_flash_model_inst.cmd_q[$], 8'hff);
        chk({7'h00, rb_n}, 8'h01);
        chk(8'(nrh_flash_model_inst.viol), 8'h00);
        chk({7'h00, wp_n}, 8'h00);
        slow = 1'b0;
        $display("test slow busy done");
    endtask
    task automatic give_verdict();
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (8) @(negedge clk);
        t_page();
        t_cache();
        t_col();
        t_slow();
        give_verdict();
    end
    // Watchdog well past the few hundred cycles the tests need
    initial begin
        #160000;
        failures++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
`default_nettype wire
